/* File: design/stt_timer.sv */
// Standard timer: 16-bit counter with compare, PWM, single pulse and capture modes
`timescale 1ns/1ps
`include "stt_params.svh"

module stt_timer #(
    parameter int PRESC_W = 2 // Sets the internal clock divider width: the divider is PRESC_W+2 bits
) (
    // Clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RSTN_I,
    // Avalon-MM slave
    input wire logic [3:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    // Pins
    input wire logic EXT_CLK_PIN_I,
    input wire logic CAPTURE_PIN_I,
    output logic TIMER_PIN_O,
    output logic TIMER_PIN_OE_O,
    output logic TIMER_EVENT_O
);

    // Elaboration check on the divider width
    if (PRESC_W < 1 || PRESC_W > 4) begin : g_bad_presc
        $error("PRESC_W must lie between 1 and 4");
    end

    // ****************************************
    // Registers
    // ****************************************
    logic run;                 // Counter run bit
    logic pause;               // Counter pause
    logic [2:0] clk_sel;       // Counter clock source
    stt_pkg::stt_mode_t mode;  // Operating mode
    logic [1:0] pin_fn;        // Pin function
    logic init_lvl;            // Initial level / active level
    logic invert;              // Output invert
    logic swap;                // Duty/period swap
    logic cclr;                // Counter clear select
    logic [15:0] cmp_a;        // Compare A value
    logic [7:0] period;        // Period compare byte
    logic [15:0] count;        // Counter
    logic flag_a;              // Match A flag
    logic flag_p;              // Match P flag
    logic run_d;               // Run bit one cycle late, for the rising edge
    logic out_lvl;             // Internal pin level before the mode gating
    logic [PRESC_W+1:0] presc; // Divider for the slow internal rates
    stt_pkg::stt_bus_t bus_st; // Bus handshake state
    // Pin synchronisers: stage one feeds stage two only
    logic ck_s1, ck_s2, ck_s3;
    logic cp_s1, cp_s2, cp_s3;

    // ****************************************
    // Synchronisers
    // ****************************************
    // Two flops per pin, a third for edge detection
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            {ck_s1, ck_s2, ck_s3} <= 3'h0;
            {cp_s1, cp_s2, cp_s3} <= 3'h0;
        end else begin
            {ck_s1, ck_s2, ck_s3} <= {EXT_CLK_PIN_I, ck_s1, ck_s2};
            {cp_s1, cp_s2, cp_s3} <= {CAPTURE_PIN_I, cp_s1, cp_s2};
        end
    end
    logic ck_rise, ck_fall, cp_rise, cp_fall;
    assign ck_rise = ck_s2 & ~ck_s3;
    assign ck_fall = ~ck_s2 & ck_s3;
    assign cp_rise = cp_s2 & ~cp_s3;
    assign cp_fall = ~cp_s2 & cp_s3;

    // ****************************************
    // Counter clock enable
    // ****************************************
    // Slow internal sources come from a free divider; the external pin
    // edge sources act as the enable themselves.
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            presc <= '0;
        end else begin
            presc <= presc + 1'b1;
        end
    end
    logic tick;
    always_comb begin
        case (clk_sel)
            3'h0: tick = &presc[1:0];
            3'h1: tick = 1'b1;
            3'h3: tick = &presc[PRESC_W:0];
            3'h6: tick = ck_rise;
            3'h7: tick = ck_fall;
            default: tick = &presc;                   // Codes 2, 4 and 5 share the slowest rate
        endcase
    end

    // ****************************************
    // Comparators and mode decode
    // ****************************************
    logic is_pwm, is_pulse, is_cap, is_cmp;
    logic match_p, match_a, run_rise, cnt_en, clr_cnt;
    logic [16:0] per_len, duty_len;
    assign is_pwm = (mode == stt_pkg::STT_MODE_PWM) && (pin_fn != 2'h3);
    assign is_pulse = (mode == stt_pkg::STT_MODE_PWM) && (pin_fn == 2'h3);
    assign is_cap = (mode == stt_pkg::STT_MODE_CAP);
    assign is_cmp = (mode == stt_pkg::STT_MODE_CMP) || (mode == stt_pkg::STT_MODE_TMR);
    assign cnt_en = run && !pause && tick;
    assign run_rise = run && !run_d;
    // Last count before the high byte reaches the period byte, so period x 256 clocks
    assign match_p = cnt_en && (count == ((period == `STT_RST_BYTE) ? 16'hFFFF : {period - 8'h01, 8'hFF}));
    assign match_a = cnt_en && (count == cmp_a - 16'h0001);
    // Period and duty lengths for the PWM comparison
    assign per_len = (period == `STT_RST_BYTE) ? 17'h10000 : {1'b0, period, 8'h00};
    assign duty_len = {1'b0, cmp_a};
    // Which match restarts the counter in each mode
    always_comb begin
        if (is_pulse) begin
            clr_cnt = 1'b0;
        end else if (is_pwm) begin
            clr_cnt = swap ? match_a : match_p;
        end else if (is_cap) begin
            clr_cnt = match_p;
        end else begin
            clr_cnt = cclr ? match_a : match_p;
        end
    end

    // ****************************************
    // Counter
    // ****************************************
    // Run rise zeroes it; a stopped counter keeps its value
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            count <= `STT_RST_WORD;
        end else if (run_rise) begin
            count <= `STT_RST_WORD;
        end else if (clr_cnt) begin
            count <= `STT_RST_WORD;
        end else if (cnt_en) begin
            count <= count + 16'h0001;                // Natural wrap when period byte is zero
        end
    end

    // ****************************************
    // Output level
    // ****************************************
    // Compare mode acts on A match only; run rise reloads the initial level
    logic pwm_active;
    always_comb begin
        if (swap) begin
            pwm_active = (per_len >= duty_len) || ({1'b0, count} < per_len);
        end else begin
            pwm_active = (duty_len >= per_len) || ({1'b0, count} < duty_len);
        end
    end
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            out_lvl <= 1'b0;
        end else if (run_rise && !is_pwm && !is_pulse) begin
            out_lvl <= init_lvl;
        end else if (mode == stt_pkg::STT_MODE_CMP && match_a) begin
            case (pin_fn)
                2'h1: out_lvl <= 1'b0;
                2'h2: out_lvl <= 1'b1;
                2'h3: out_lvl <= ~out_lvl;
                default: out_lvl <= out_lvl;
            endcase
        end
    end
    // Final pin level with active level and invert
    logic next_pin;
    always_comb begin
        if (is_pwm) begin
            case (pin_fn)
                2'h0: next_pin = ~init_lvl;
                2'h1: next_pin = init_lvl;
                default: next_pin = run ? (pwm_active ? init_lvl : ~init_lvl) : ~init_lvl;
            endcase
            next_pin = next_pin ^ invert;
        end else if (is_pulse) begin
            next_pin = (run ? init_lvl : ~init_lvl) ^ invert;
        end else begin
            next_pin = out_lvl ^ invert;
        end
    end
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            TIMER_PIN_O <= 1'b0;
            TIMER_PIN_OE_O <= 1'b0;
        end else begin
            TIMER_PIN_O <= next_pin;
            // Timer/counter and capture leave the pin free
            TIMER_PIN_OE_O <= (mode == stt_pkg::STT_MODE_CMP) || (mode == stt_pkg::STT_MODE_PWM);
        end
    end

    // ****************************************
    // Capture
    // ****************************************
    logic cap_evt;
    always_comb begin
        case (pin_fn)
            2'h0: cap_evt = cp_rise;
            2'h1: cap_evt = cp_fall;
            2'h2: cap_evt = cp_rise | cp_fall;
            default: cap_evt = 1'b0;
        endcase
        cap_evt = cap_evt && is_cap && run;
    end

    // ****************************************
    // Bus slave
    // ****************************************
    // One wait cycle on every access, then ack
    logic acc, wr_acc;
    assign acc = (AVS_READ_I || AVS_WRITE_I) && (bus_st == stt_pkg::STT_BUS_ACK);
    assign wr_acc = acc && AVS_WRITE_I;
    // Waitrequest is a flop of its own, low in the cycle after a request is seen
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            bus_st <= stt_pkg::STT_BUS_IDLE;
            AVS_WAITREQUEST_O <= 1'b1;
        end else begin
            AVS_WAITREQUEST_O <= !((bus_st == stt_pkg::STT_BUS_IDLE) && (AVS_READ_I || AVS_WRITE_I));
            case (bus_st)
                stt_pkg::STT_BUS_IDLE: bus_st <= (AVS_READ_I || AVS_WRITE_I) ? stt_pkg::STT_BUS_ACK
                                                                              : stt_pkg::STT_BUS_IDLE;
                default: bus_st <= stt_pkg::STT_BUS_IDLE;
            endcase
        end
    end

    // Control registers; hardware run set/clear wins over a same-cycle write
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            {pause, clk_sel, run} <= 5'h00;
            mode <= stt_pkg::STT_MODE_CMP;
            {pin_fn, init_lvl, invert, swap, cclr} <= 6'(`STT_RST_BYTE);
            period <= `STT_RST_BYTE;
            run_d <= 1'b0;
        end else begin
            run_d <= run;
            if (wr_acc && AVS_ADDRESS_I == `STT_ADDR_CTRL0) begin
                pause <= AVS_WRITEDATA_I[`STT_C0_PAUSE];
                clk_sel <= AVS_WRITEDATA_I[`STT_C0_CLKSEL_HI:`STT_C0_CLKSEL_LO];
                run <= AVS_WRITEDATA_I[`STT_C0_RUN];
            end
            if (wr_acc && AVS_ADDRESS_I == `STT_ADDR_CTRL1) begin
                mode <= stt_pkg::stt_mode_t'(AVS_WRITEDATA_I[`STT_C1_MODE_HI:`STT_C1_MODE_LO]);
                pin_fn <= AVS_WRITEDATA_I[`STT_C1_PIN_HI:`STT_C1_PIN_LO];
                init_lvl <= AVS_WRITEDATA_I[`STT_C1_INIT];
                invert <= AVS_WRITEDATA_I[`STT_C1_INV];
                swap <= AVS_WRITEDATA_I[`STT_C1_SWAP];
                cclr <= AVS_WRITEDATA_I[`STT_C1_CCLR];
            end
            if (wr_acc && AVS_ADDRESS_I == `STT_ADDR_PERIOD) begin
                period <= AVS_WRITEDATA_I[7:0];
            end
            if (is_pulse && match_a && run) begin
                run <= 1'b0;
            end else if (is_pulse && !run && ck_rise) begin
                run <= 1'b1;
            end
        end
    end
    // Compare A: software write, or capture copy which wins
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            cmp_a <= `STT_RST_WORD;
        end else if (cap_evt) begin
            cmp_a <= count;
        end else if (wr_acc && AVS_ADDRESS_I == `STT_ADDR_CMPA) begin
            cmp_a <= AVS_WRITEDATA_I[15:0];
        end
    end
    // Flags: write one to clear, a same-cycle event wins
    logic set_a, set_p;
    assign set_a = (match_a && !is_cap) || cap_evt;
    assign set_p = match_p && !(is_cmp && cclr) && !is_pulse;
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            flag_a <= 1'b0;
            flag_p <= 1'b0;
            TIMER_EVENT_O <= 1'b0;
        end else begin
            flag_a <= set_a | (flag_a & ~(wr_acc && AVS_ADDRESS_I == `STT_ADDR_FLAGS
                                          && AVS_WRITEDATA_I[`STT_FL_A]));
            flag_p <= set_p | (flag_p & ~(wr_acc && AVS_ADDRESS_I == `STT_ADDR_FLAGS
                                          && AVS_WRITEDATA_I[`STT_FL_P]));
            TIMER_EVENT_O <= set_a | set_p;           // One-cycle timer event pulse
        end
    end
    // Read data registered on the edge that first sees the read, one edge before the ack
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            AVS_READDATA_O <= `STT_RST_BUS;
        end else if (bus_st == stt_pkg::STT_BUS_IDLE && AVS_READ_I) begin
            case (AVS_ADDRESS_I)
                `STT_ADDR_CTRL0: AVS_READDATA_O <= {24'h000000, pause, clk_sel, run, 3'h0};
                `STT_ADDR_CTRL1: AVS_READDATA_O <= {24'h000000, mode, pin_fn, init_lvl, invert, swap, cclr};
                `STT_ADDR_COUNT: AVS_READDATA_O <= {16'h0000, count};
                `STT_ADDR_CMPA: AVS_READDATA_O <= {16'h0000, cmp_a};
                `STT_ADDR_PERIOD: AVS_READDATA_O <= {24'h000000, period};
                `STT_ADDR_FLAGS: AVS_READDATA_O <= {30'h00000000, flag_p, flag_a};
                default: AVS_READDATA_O <= `STT_RST_BUS;
            endcase
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    // Run rise in compare mode; the pin shows the initial level two edges on
    sequence s_cmp_restart;
        run_rise && mode == stt_pkg::STT_MODE_CMP;
    endsequence
    a_run_clears_cnt: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
        run_rise |=> count == 16'h0000) else $error("counter not zero after run rise");
    a_stop_holds: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
        !run && !run_rise |=> $stable(count)) else $error("stopped counter moved");
    a_no_p_flag: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
        is_cmp && cclr && !flag_p |=> !flag_p) else $error("P flag with clear select high");
    a_p_flag_set: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
        match_p && (is_pwm || (is_cmp && !cclr)) |=> flag_p) else $error("P flag missed");
    a_pulse_ends: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
        is_pulse && match_a && run |=> !run) else $error("pulse run not cleared");
    a_pulse_no_clr: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
        is_pulse && cnt_en && !run_rise && !match_a |=> count == $past(count) + 16'h0001)
        else $error("pulse counter cleared");
    a_capture_copy: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
        cap_evt |=> cmp_a == $past(count) && flag_a) else $error("capture not stored");
    a_cap_disabled: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
        is_cap && pin_fn == 2'h3 && !(wr_acc && AVS_ADDRESS_I == `STT_ADDR_CMPA) |=> $stable(cmp_a))
        else $error("capture while disabled");
    a_init_level: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
        s_cmp_restart |=> ##1 TIMER_PIN_O == (init_lvl ^ invert))
        else $error("initial level not loaded");
    a_full_duty: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
        is_pwm && pin_fn == 2'h2 && run && !swap && duty_len >= per_len
        |=> TIMER_PIN_O == ($past(init_lvl) ^ $past(invert))) else $error("full duty broken");

endmodule // stt_timer

/* File: design/stt_params.svh */
// Register offsets, field positions and reset values of the standard timer
`ifndef STT_PARAMS_SVH
`define STT_PARAMS_SVH

// ****************************************
// Register word addresses (one per 32-bit register)
// ****************************************
`define STT_ADDR_CTRL0 4'h0
`define STT_ADDR_CTRL1 4'h1
`define STT_ADDR_COUNT 4'h2
`define STT_ADDR_CMPA 4'h3
`define STT_ADDR_PERIOD 4'h4
`define STT_ADDR_FLAGS 4'h5

// ****************************************
// Field positions
// ****************************************
`define STT_C0_PAUSE 7
`define STT_C0_CLKSEL_HI 6
`define STT_C0_CLKSEL_LO 4
`define STT_C0_RUN 3
`define STT_C1_MODE_HI 7
`define STT_C1_MODE_LO 6
`define STT_C1_PIN_HI 5
`define STT_C1_PIN_LO 4
`define STT_C1_INIT 3
`define STT_C1_INV 2
`define STT_C1_SWAP 1
`define STT_C1_CCLR 0
`define STT_FL_A 0
`define STT_FL_P 1
`define STT_FL_IRQ 2

// ****************************************
// Reset values
// ****************************************
`define STT_RST_BYTE 8'h00
`define STT_RST_WORD 16'h0000
`define STT_RST_PRESC 2'h3
`define STT_RST_BUS 32'h00000000

`endif

/* File: design/stt_pkg.sv */
// Types shared by the standard timer design
package stt_pkg;
    // Operating modes as held in the mode select field
    typedef enum logic [1:0] {
        STT_MODE_CMP = 2'h0,
        STT_MODE_CAP = 2'h1,
        STT_MODE_PWM = 2'h2,
        STT_MODE_TMR = 2'h3
    } stt_mode_t;
    // Bus slave handshake state
    typedef enum logic [0:0] {
        STT_BUS_IDLE,
        STT_BUS_ACK
    } stt_bus_t;
endpackage

/* File: testbench/stt_pins_model.sv */
// Behavioural model of the trigger and capture pins facing the standard timer
`timescale 1ns/1ps

module stt_pins_model (
    // Clock
    input wire logic clk_i,
    // Pins toward the timer
    output logic ext_clk_o,
    output logic capture_o
);
    // Both pins idle low; the real source has a defined level at all times
    initial begin
        ext_clk_o = 1'b0;
        capture_o = 1'b0;
    end

    // One trigger pulse, held long enough to pass the two-flop synchroniser
    task automatic ext_pulse();
        @(posedge clk_i);
        ext_clk_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        ext_clk_o <= 1'b0;
    endtask

    // Capture input level, changed only just after a clock edge
    task automatic cap_set(input logic lvl);
        @(posedge clk_i);
        capture_o <= lvl;
    endtask
endmodule // stt_pins_model

/* File: testbench/standard_timer_modes_tb.sv */
// Self-checking testbench for the standard timer operating modes
`timescale 1ns/1ps
`include "stt_params.svh"

module standard_timer_modes_tb;
    // ****************************************
    // Signals
    // ****************************************
    logic clk = 1'b0; // Core clock
    logic rst_n = 1'b0; // Reset, active low
    logic [3:0] addr = 4'h0;
    logic rd_s = 1'b0;
    logic wr_s = 1'b0;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] rdat;
    logic wreq;
    logic ext_pin;
    logic cap_pin;
    logic pin_o;
    logic pin_oe;
    logic v_evt;
    logic [31:0] v;
    logic [31:0] v2;
    logic [31:0] j; // Discarded read data of writes
    int fails = 0;
    int tests_run = 0;
    int cycles = 0;
    int hi;
    // Run with the every-cycle timer clock, or stopped with the same clock
    localparam logic [31:0] RUN = 32'h00000018;
    localparam logic [31:0] STOP = 32'h00000010;

    stt_timer dut (.CORE_CLK_I(clk), .RSTN_I(rst_n), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd_s),
        .AVS_WRITE_I(wr_s), .AVS_WRITEDATA_I(wdat), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq),
        .EXT_CLK_PIN_I(ext_pin), .CAPTURE_PIN_I(cap_pin), .TIMER_PIN_O(pin_o), .TIMER_PIN_OE_O(pin_oe),
        .TIMER_EVENT_O(v_evt));
    stt_pins_model pins (.clk_i(clk), .ext_clk_o(ext_pin), .capture_o(cap_pin));

    // 100 MHz clock
    initial begin
        forever #5 clk = ~clk;
    end

    // Hang guard: far above the few thousand cycles the scenarios need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            print_verdict();
        end
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    // Compare and count; case inequality so an unknown never matches
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One Avalon access; request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        addr <= a;
        wdat <= d;
        wr_s <= w;
        rd_s <= ~w;
        do begin
            @(posedge clk);
        end while (wreq !== 1'b0);
        q = rdat;
        wr_s <= 1'b0;
        rd_s <= 1'b0;
    endtask

    // Control word 1: mode, pin function, then init/invert/swap/clear-select
    function automatic logic [31:0] c1(input logic [1:0] m, input logic [1:0] p, input logic [3:0] lo);
        c1 = {24'h000000, m, p, lo};
    endfunction

    // Stop, program, clear flags and optionally start the timer
    task automatic setup(input logic [31:0] cv, input logic [31:0] a, input logic [31:0] p, input logic run);
        bus(1'b1, `STT_ADDR_CTRL0, STOP, j);
        bus(1'b1, `STT_ADDR_CTRL1, cv, j);
        bus(1'b1, `STT_ADDR_CMPA, a, j);
        bus(1'b1, `STT_ADDR_PERIOD, p, j);
        bus(1'b1, `STT_ADDR_FLAGS, 32'h00000003, j);
        if (run) begin
            bus(1'b1, `STT_ADDR_CTRL0, RUN, j);
        end
    endtask

    // Count cycles with the pin high
    task automatic hcount(input int n);
        hi = 0;
        repeat (n) begin
            @(posedge clk);
            if (pin_o === 1'b1) begin
                hi = hi + 1;
            end
        end
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    // Reset values, unmapped place, read-only counter
    task automatic t_regs();
        bus(1'b0, `STT_ADDR_PERIOD, 32'h0, v);
        chk(v, 32'h00000000);
        bus(1'b0, 4'hF, 32'h0, v);
        chk(v, 32'h00000000);
        bus(1'b1, `STT_ADDR_COUNT, 32'h00001234, j);
        bus(1'b0, `STT_ADDR_COUNT, 32'h0, v);
        chk(v, 32'h00000000);
    endtask

    // Compare A clears; with clear select high, P never flags
    task automatic t_cmp_aclr();
        setup(c1(stt_pkg::STT_MODE_CMP, 2'b01, 4'b1001), 32'h00000300, 32'h01, 1'b1); // Non-zero A
        repeat (3) @(posedge clk);
        chk(32'(pin_o), 32'h1);
        chk(32'(pin_oe), 32'h1);
        repeat (850) @(posedge clk);
        chk(32'(pin_o), 32'h0);
        bus(1'b1, `STT_ADDR_CTRL0, STOP, j);
        bus(1'b0, `STT_ADDR_FLAGS, 32'h0, v);
        chk(v, 32'h00000001);
        bus(1'b1, `STT_ADDR_FLAGS, 32'h00000003, j);
        bus(1'b0, `STT_ADDR_FLAGS, 32'h0, v);
        chk(v, 32'h00000000);
    endtask

    // Period match clears; stop holds count; restart zeroes it
    task automatic t_cmp_pclr();
        setup(c1(stt_pkg::STT_MODE_CMP, 2'b10, 4'b0000), 32'h00000020, 32'h01, 1'b1);
        repeat (3) @(posedge clk);
        chk(32'(pin_o), 32'h0);
        repeat (300) @(posedge clk);
        chk(32'(pin_o), 32'h1);
        bus(1'b0, `STT_ADDR_FLAGS, 32'h0, v);
        chk(v, 32'h00000003);
        bus(1'b0, `STT_ADDR_COUNT, 32'h0, v);
        chk(32'(v < 32'h100), 32'h1); // Wrapped after 256 clocks
        bus(1'b1, `STT_ADDR_CTRL0, STOP, j);
        bus(1'b0, `STT_ADDR_COUNT, 32'h0, v);
        repeat (20) @(posedge clk);
        bus(1'b0, `STT_ADDR_COUNT, 32'h0, v2);
        chk(v2, v);
        bus(1'b1, `STT_ADDR_CTRL0, RUN, j);
        repeat (3) @(posedge clk);
        chk(32'(pin_o), 32'h0);
        bus(1'b0, `STT_ADDR_COUNT, 32'h0, v);
        chk(32'(v < 32'h10), 32'h1);
    endtask

    // Timer mode: same flags, pin left free
    task automatic t_timer();
        setup(c1(stt_pkg::STT_MODE_TMR, 2'b11, 4'b1000), 32'h00000020, 32'h01, 1'b1);
        // Three event pulses: A match at count 1F, period match at FF, A match again
        hi = 0;
        repeat (300) begin
            @(posedge clk);
            hi = hi + int'(v_evt === 1'b1);
        end
        chk(32'(hi), 32'd3);
        chk(32'(pin_oe), 32'h0);
        bus(1'b0, `STT_ADDR_FLAGS, 32'h0, v);
        chk(v, 32'h00000003);
    endtask

    // PWM duty, swap, full duty, level and invert, forced levels
    task automatic t_pwm();
        for (int i = 0; i < 4; i++) begin
            setup(c1(stt_pkg::STT_MODE_PWM, 2'b10, {i[1], i[0], 2'b01}), 32'h40, 32'h01, 1'b1);
            repeat (20) @(posedge clk);
            hcount(512);
            chk(32'(hi >= ((i[1] ^ i[0]) ? 126 : 382) && hi <= ((i[1] ^ i[0]) ? 130 : 386)), 32'h1);
        end
        bus(1'b0, `STT_ADDR_FLAGS, 32'h0, v);
        chk(v, 32'h00000003);
        setup(c1(stt_pkg::STT_MODE_PWM, 2'b10, 4'b1010), 32'h300, 32'h01, 1'b1);
        repeat (20) @(posedge clk);
        hcount(768);
        chk(32'(hi >= 254 && hi <= 258), 32'h1);
        setup(c1(stt_pkg::STT_MODE_PWM, 2'b10, 4'b1000), 32'h200, 32'h01, 1'b1);
        repeat (20) @(posedge clk);
        hcount(512);
        chk(32'(hi), 32'd512);
        for (int p = 0; p < 2; p++) begin
            setup(c1(stt_pkg::STT_MODE_PWM, p[1:0], 4'b1000), 32'h40, 32'h01, 1'b1);
            repeat (20) @(posedge clk);
            hcount(256);
            chk(32'(hi), p ? 32'd256 : 32'd0);
        end
    endtask

    // Single pulse started from the trigger pin, ended by compare A
    task automatic t_single();
        setup(c1(stt_pkg::STT_MODE_PWM, 2'b11, 4'b1001), 32'h20, 32'h01, 1'b0); // Function kept at 11
        pins.ext_pulse();
        repeat (4) @(posedge clk);
        bus(1'b0, `STT_ADDR_CTRL0, 32'h0, v);
        chk(32'(v[`STT_C0_RUN]), 32'h1);
        chk(32'(pin_o), 32'h1);
        repeat (60) @(posedge clk);
        chk(32'(pin_o), 32'h0);
        bus(1'b0, `STT_ADDR_CTRL0, 32'h0, v);
        chk(32'(v[`STT_C0_RUN]), 32'h0);
        bus(1'b0, `STT_ADDR_COUNT, 32'h0, v);
        repeat (10) @(posedge clk);
        bus(1'b0, `STT_ADDR_COUNT, 32'h0, v2);
        chk(32'(v2 == v && v != 32'h0), 32'h1);
    endtask

    // Capture on each edge selection, disabled selection, period wrap
    task automatic t_capture();
        for (int p = 0; p < 4; p++) begin
            setup(c1(stt_pkg::STT_MODE_CAP, p[1:0], 4'b0000), 32'hFFFF, 32'h01, 1'b1);
            pins.cap_set(1'b1);
            repeat (10) @(posedge clk);
            bus(1'b0, `STT_ADDR_CMPA, 32'h0, v);
            chk(32'(v[15:0] !== 16'hFFFF), 32'(p == 0 || p == 2));
            bus(1'b1, `STT_ADDR_CMPA, 32'hFFFF, j);
            pins.cap_set(1'b0);
            repeat (10) @(posedge clk);
            bus(1'b0, `STT_ADDR_CMPA, 32'h0, v);
            chk(32'(v[15:0] !== 16'hFFFF), 32'(p == 1 || p == 2));
        end
        repeat (300) @(posedge clk);
        bus(1'b0, `STT_ADDR_FLAGS, 32'h0, v);
        chk(32'(v[`STT_FL_P]), 32'h1);
        bus(1'b0, `STT_ADDR_COUNT, 32'h0, v);
        repeat (5) @(posedge clk);
        bus(1'b0, `STT_ADDR_COUNT, 32'h0, v2);
        chk(32'(v2 != v && v2 < 32'h100), 32'h1); // Still counting with capture off
    endtask

    // ****************************************
    // Verdict and main sequence
    // ****************************************
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_cmp_aclr();
        t_cmp_pclr();
        t_timer();
        t_pwm();
        t_single();
        t_capture();
        print_verdict();
    end
endmodule // standard_timer_modes_tb
